// ### src/odg_pkg.sv
// Purpose: Shared constants and types for the geared output and tristate path
// Assumes: One clock; registers reached over Avalon-MM
// Notes: Offsets are byte addresses of aligned 32-bit words
package odg_pkg;

  // Register byte offsets
  localparam logic [3:0] OFS_CTRL = 4'h0;
  localparam logic [3:0] OFS_SMEAR = 4'h4;
  localparam logic [3:0] OFS_LEVEL = 4'h8;
  localparam logic [3:0] OFS_STATUS = 4'hC;

  // Control field positions
  localparam int CTRL_MODE_LSB = 0;
  localparam int CTRL_LATCH_BIT = 2;
  localparam int CTRL_SMEAR_EN_BIT = 3;

  // Status field positions
  localparam int STAT_MODE_LSB = 0;
  localparam int STAT_DATA_BIT = 2;
  localparam int STAT_OE_BIT = 3;
  localparam int STAT_LEVEL_LSB = 4;

  // Reset values
  localparam logic [1:0] RST_MODE = 2'h0;
  localparam logic [2:0] RST_SMEAR = 3'h0;
  localparam logic [7:0] RST_LEVEL = 8'h00;

  // Last phase index per captured word
  localparam logic [1:0] LAST_PH_SDR = 2'h0;
  localparam logic [1:0] LAST_PH_DDR = 2'h1;
  localparam logic [1:0] LAST_PH_GEAR = 2'h3;

  // Output modes
  typedef enum logic [1:0] {
    MODE_SDR,
    MODE_DDR,
    MODE_GEAR
  } odg_mode_t;

  // Placement of the instance on the die
  typedef enum logic [1:0] {
    EDGE_LEFT,
    EDGE_RIGHT,
    EDGE_TOP,
    EDGE_BOTTOM
  } odg_edge_t;

  // One word from the core: four data streams and the driver-off request
  typedef struct packed {
    logic driver_off_request;
    logic fall_data_b;
    logic rise_data_b;
    logic fall_data_a;
    logic rise_data_a;
  } odg_word_t;

  // What goes to the pad buffer
  typedef struct packed {
    logic [6:0] level_steps;
    logic level_invert;
    logic [2:0] smear_delay;
    logic oe;
    logic data;
  } odg_pad_t;

endpackage : odg_pkg

// ### src/odg_top.sv
// Purpose: Output and tristate register path with SDR, DDR and 4:1 gearing
// Assumes: clk is the edge rate; one pad bit per clk cycle; core on the same clock
// Notes: Gearing clocks are derived from the phase counter inside this block
// Operation
// - SDR passes rise A via flop or latch
// - DDR captures two, latches one next cycle
// - DDR selector alternates both half-cycle values
// - Gearbox captures four, latches two
// - Gear clocks serialize four streams at rate
// - Gearing only on left and right edges
// - SDR/DDR tristate through one flop
// - Gear mode re-registers tristate on gear clocks
// - Smear correction per pin, gear mode only
// - Long runs get no stretching
// - Pattern 010 stretches the one
// - Pattern 101 stretches the zero
// - Three-bit value sets stretch amount
// - Eight-bit leveling code, 128 delay steps
// - Code MSB inverts clock, half period
//
// Design decisions made here: the Avalon-MM interface to the registers and the placing of the registers.

// Small flop-based FIFO with valid/ready on both sides
module odg_fifo #(
  parameter int WIDTH = 5,
  parameter int DEPTH = 8
) (
  // Clock and reset
  input wire logic clk,
  input wire logic sys_rst,
  // Fill side
  input wire logic in_valid,
  output logic in_ready,
  input wire logic [WIDTH-1:0] in_data,
  // Drain side
  output logic out_valid,
  input wire logic out_ready,
  output logic [WIDTH-1:0] out_data,
  // Fill level
  output logic [$clog2(DEPTH+1)-1:0] level
);
  localparam int AW = $clog2(DEPTH);
  localparam int CW = $clog2(DEPTH + 1);
  logic [WIDTH-1:0] mem_ff [DEPTH]; // Storage
  logic [AW-1:0] wr_ff; // Write index
  logic [AW-1:0] rd_ff; // Read index
  logic [$clog2(DEPTH+1)-1:0] cnt_ff; // Words held
  logic push; // Word accepted
  logic pop; // Word delivered

  assign in_ready = (cnt_ff != CW'(DEPTH));
  assign out_valid = (cnt_ff != '0);
  assign out_data = mem_ff[rd_ff];
  assign level = cnt_ff;
  assign push = in_valid & in_ready;
  assign pop = out_valid & out_ready;

  // Storage write
  always_ff @(posedge clk)
  begin
    if (push)
    begin
      mem_ff[wr_ff] <= in_data;
    end
  end

  // Pointers wrap at depth
  always_ff @(posedge clk or posedge sys_rst)
  begin
    if (sys_rst)
    begin
      wr_ff <= '0;
      rd_ff <= '0;
    end
    else
    begin
      if (push)
        wr_ff <= (wr_ff == AW'(DEPTH - 1)) ? '0 : wr_ff + 1'b1;
      if (pop)
        rd_ff <= (rd_ff == AW'(DEPTH - 1)) ? '0 : rd_ff + 1'b1;
    end
  end

  // Occupancy count
  always_ff @(posedge clk or posedge sys_rst)
  begin
    if (sys_rst)
      cnt_ff <= '0;
    else if (push && !pop)
      cnt_ff <= cnt_ff + 1'b1;
    else if (pop && !push)
      cnt_ff <= cnt_ff - 1'b1;
  end

  // Never more than depth words
  a_fifo_bound: assert property (@(posedge clk) disable iff (sys_rst)
    cnt_ff <= DEPTH) else $error("fifo count above depth");
endmodule // odg_fifo

module odg_top
  import odg_pkg::*;
#(
  parameter odg_edge_t EDGE = EDGE_LEFT,
  parameter int FIFO_DEPTH = 8
) (
  // Clock and reset
  input wire logic clk,
  input wire logic sys_rst,
  // Avalon-MM register slave
  input wire logic [3:0] avs_address,
  input wire logic avs_read,
  input wire logic avs_write,
  input wire logic [31:0] avs_writedata,
  input wire logic [3:0] avs_byteenable,
  output logic [31:0] avs_readdata,
  output logic avs_waitrequest,
  // Core word stream
  input wire logic core_valid,
  output logic core_ready,
  input wire odg_pkg::odg_word_t core_word,
  // Pad buffer side
  output odg_pkg::odg_pad_t pad,
  output logic gear_clock_zero,
  output logic gear_clock_one
);
  import odg_pkg::*;

  // Register file
  logic [1:0] mode_ff; // Requested mode
  logic latch_ff; // SDR storage as latch
  logic smear_en_ff; // Correction enable
  logic [2:0] smear_amt_ff; // Stretch amount
  logic [7:0] level_ff; // leveling_delay_code
  logic ack_ff; // Bus answer phase
  logic [31:0] rdata_ff; // Read data
  // Data path
  odg_word_t head; // FIFO head word
  logic head_valid; // FIFO holds a word
  logic take; // Word taken this cycle
  logic [$clog2(FIFO_DEPTH+1)-1:0] fifo_level; // FIFO occupancy
  odg_mode_t eff_mode; // Mode after edge limits
  logic [1:0] last_ph; // Last phase of a word
  logic [1:0] ph_ff; // Serializer phase
  odg_word_t cap_ff; // Captured word
  logic [1:0] lat_ff; // Latched fall values
  logic ts_ff; // Registered driver-off
  logic ts2_ff; // Gear-clock tristate register
  logic sel_bit; // Serialized bit
  logic oe_sel; // Selected enable
  logic [1:0] hist_ff; // Two previous serialized bits
  logic oe_d_ff; // Enable aligned to history
  logic isolated; // Middle bit is isolated

  // Bus strobes and decode
  logic req;
  assign req = avs_read | avs_write;
  assign avs_waitrequest = req & ~ack_ff;
  assign avs_readdata = rdata_ff;

  // Answer one cycle after the request is seen
  always_ff @(posedge clk or posedge sys_rst)
  begin
    if (sys_rst)
      ack_ff <= 1'b0;
    else
      ack_ff <= req & ~ack_ff;
  end

  // Read data registered while waitrequest is high
  always_ff @(posedge clk or posedge sys_rst)
  begin
    if (sys_rst)
      rdata_ff <= '0;
    else if (avs_read && !ack_ff)
    begin
      rdata_ff <= '0;
      case (avs_address)
        OFS_CTRL:
        begin
          rdata_ff[CTRL_MODE_LSB +: 2] <= mode_ff;
          rdata_ff[CTRL_LATCH_BIT] <= latch_ff;
          rdata_ff[CTRL_SMEAR_EN_BIT] <= smear_en_ff;
        end
        OFS_SMEAR: rdata_ff[2:0] <= smear_amt_ff;
        OFS_LEVEL: rdata_ff[7:0] <= level_ff;
        OFS_STATUS:
        begin
          rdata_ff[STAT_MODE_LSB +: 2] <= eff_mode;
          rdata_ff[STAT_DATA_BIT] <= pad.data;
          rdata_ff[STAT_OE_BIT] <= pad.oe;
          rdata_ff[STAT_LEVEL_LSB +: $bits(fifo_level)] <= fifo_level;
        end
        // Unmapped reads return zero
        default: rdata_ff <= '0;
      endcase
    end
  end

  // Register writes take effect at the answer edge
  always_ff @(posedge clk or posedge sys_rst)
  begin
    if (sys_rst)
    begin
      mode_ff <= RST_MODE;
      latch_ff <= 1'b0;
      smear_en_ff <= 1'b0;
      smear_amt_ff <= RST_SMEAR;
      level_ff <= RST_LEVEL;
    end
    else if (avs_write && ack_ff && avs_byteenable[0])
    begin
      case (avs_address)
        OFS_CTRL:
        begin
          mode_ff <= avs_writedata[CTRL_MODE_LSB +: 2];
          latch_ff <= avs_writedata[CTRL_LATCH_BIT];
          smear_en_ff <= avs_writedata[CTRL_SMEAR_EN_BIT];
        end
        OFS_SMEAR: smear_amt_ff <= avs_writedata[2:0];
        OFS_LEVEL: level_ff <= avs_writedata[7:0];
        // Unmapped writes are dropped
        default: ;
      endcase
    end
  end

  // Buffer between core and serializer
  odg_fifo #(
    .WIDTH($bits(odg_word_t)),
    .DEPTH(FIFO_DEPTH)
  ) u_fifo (
    .clk(clk),
    .sys_rst(sys_rst),
    .in_valid(core_valid),
    .in_ready(core_ready),
    .in_data(core_word),
    .out_valid(head_valid),
    .out_ready(take),
    .out_data(head),
    .level(fifo_level)
  );

  // Gearing only where the edge has it; top and bottom fall back to DDR
  always_comb
  begin
    case (mode_ff)
      2'h0: eff_mode = MODE_SDR;
      2'h1: eff_mode = MODE_DDR;
      default: eff_mode = (EDGE == EDGE_LEFT || EDGE == EDGE_RIGHT) ? MODE_GEAR : MODE_DDR;
    endcase
  end

  // Phases per word
  always_comb
  begin
    case (eff_mode)
      MODE_SDR: last_ph = LAST_PH_SDR;
      MODE_DDR: last_ph = LAST_PH_DDR;
      default: last_ph = LAST_PH_GEAR;
    endcase
  end

  // A word is taken on the last phase; the FIFO backs up while busy
  assign take = head_valid && (ph_ff >= last_ph);

  // Phase counter doubles as the two gearing clocks
  always_ff @(posedge clk or posedge sys_rst)
  begin
    if (sys_rst)
      ph_ff <= '0;
    else if (ph_ff >= last_ph)
      ph_ff <= '0;
    else
      ph_ff <= ph_ff + 1'b1;
  end
  assign gear_clock_zero = ph_ff[0];
  assign gear_clock_one = ph_ff[1];

  // Capture all four streams and the driver-off request
  always_ff @(posedge clk or posedge sys_rst)
  begin
    if (sys_rst)
    begin
      cap_ff <= '0;
      ts_ff <= 1'b1;
    end
    else if (take)
    begin
      cap_ff <= head;
      ts_ff <= head.driver_off_request;
    end
  end

  // Fall values latched in the cycle after capture
  always_ff @(posedge clk or posedge sys_rst)
  begin
    if (sys_rst)
      lat_ff <= '0;
    else if (ph_ff == 2'h0)
      lat_ff <= {cap_ff.fall_data_b, cap_ff.fall_data_a};
  end

  // Tristate re-registered on the gear clock phase
  always_ff @(posedge clk or posedge sys_rst)
  begin
    if (sys_rst)
      ts2_ff <= 1'b1;
    else if (ph_ff == 2'h0)
      ts2_ff <= ts_ff;
  end

  // Output selector
  always_comb
  begin
    sel_bit = cap_ff.rise_data_a;
    case (eff_mode)
      MODE_SDR:
      begin
        // Latch is transparent to the word being taken
        if (latch_ff && take)
          sel_bit = head.rise_data_a;
        else
          sel_bit = cap_ff.rise_data_a;
      end
      MODE_DDR:
        sel_bit = ph_ff[0] ? lat_ff[0] : cap_ff.rise_data_a;
      default:
      begin
        case ({gear_clock_one, gear_clock_zero})
          2'h0: sel_bit = cap_ff.rise_data_a;
          2'h1: sel_bit = lat_ff[0];
          2'h2: sel_bit = cap_ff.rise_data_b;
          default: sel_bit = lat_ff[1];
        endcase
      end
    endcase
  end

  // Enable source depends on gearing
  assign oe_sel = (eff_mode == MODE_GEAR) ? ~ts2_ff : ~ts_ff;

  // Shift history of the serialized bits
  always_ff @(posedge clk or posedge sys_rst)
  begin
    if (sys_rst)
    begin
      hist_ff <= '0;
      oe_d_ff <= 1'b0;
    end
    else
    begin
      hist_ff <= {hist_ff[0], sel_bit};
      oe_d_ff <= oe_sel;
    end
  end

  // Middle bit differs from both neighbours: 010 or 101
  assign isolated = (hist_ff[0] != hist_ff[1]) && (hist_ff[0] != sel_bit);

  // Pad outputs from flops
  always_ff @(posedge clk or posedge sys_rst)
  begin
    if (sys_rst)
      pad <= '0;
    else
    begin
      pad.data <= hist_ff[0];
      pad.oe <= oe_d_ff;
      // Stretch only isolated bits, only when geared
      if (smear_en_ff && eff_mode == MODE_GEAR && isolated)
        pad.smear_delay <= smear_amt_ff;
      else
        pad.smear_delay <= '0;
      pad.level_steps <= level_ff[6:0];
      pad.level_invert <= level_ff[7];
    end
  end

  // Checks
  a_sdr_flop_path: assert property (@(posedge clk) disable iff (sys_rst)
    (eff_mode == MODE_SDR && !latch_ff && $stable(eff_mode)) ##1 (eff_mode == MODE_SDR && !latch_ff)
    |-> ##2 pad.data == $past(cap_ff.rise_data_a, 2)) else $error("sdr data path wrong");
  a_ddr_two_phase: assert property (@(posedge clk) disable iff (sys_rst)
    (eff_mode == MODE_DDR && $stable(eff_mode)) |-> ph_ff <= LAST_PH_DDR) else $error("ddr phase out of range");
  a_ddr_fall_latch: assert property (@(posedge clk) disable iff (sys_rst)
    (eff_mode != MODE_SDR && ph_ff == 2'h0) |=> lat_ff[0] == $past(cap_ff.fall_data_a)) else $error("fall latch missed");
  a_gear_rise_b: assert property (@(posedge clk) disable iff (sys_rst)
    (eff_mode == MODE_GEAR && ph_ff == 2'h2) |-> sel_bit == cap_ff.rise_data_b) else $error("gear select wrong");
  a_gear_edge_only: assert property (@(posedge clk) disable iff (sys_rst)
    (EDGE == EDGE_TOP || EDGE == EDGE_BOTTOM) |-> eff_mode != MODE_GEAR) else $error("gearing on wrong edge");
  a_oe_tracks_ts: assert property (@(posedge clk) disable iff (sys_rst)
    (eff_mode != MODE_GEAR) ##1 (eff_mode != MODE_GEAR) |=> pad.oe == !$past(ts_ff, 2)) else $error("enable not from flop");
  a_gear_ts_stage: assert property (@(posedge clk) disable iff (sys_rst)
    (ph_ff == 2'h0) |=> ts2_ff == $past(ts_ff)) else $error("gear tristate stage missed");
  a_smear_gear_only: assert property (@(posedge clk) disable iff (sys_rst)
    (eff_mode != MODE_GEAR && $stable(eff_mode)) |=> pad.smear_delay == 3'h0) else $error("stretch outside gearing");
  a_no_stretch_run: assert property (@(posedge clk) disable iff (sys_rst)
    (hist_ff[0] == hist_ff[1]) |=> pad.smear_delay == 3'h0) else $error("stretch on a run");
  a_stretch_iso: assert property (@(posedge clk) disable iff (sys_rst)
    (smear_en_ff && eff_mode == MODE_GEAR && hist_ff == 2'b01 && !sel_bit)
    |=> pad.smear_delay == $past(smear_amt_ff) && pad.data) else $error("isolated one not stretched");
  a_level_code: assert property (@(posedge clk) disable iff (sys_rst)
    1'b1 |=> pad.level_invert == $past(level_ff[7]) && pad.level_steps == $past(level_ff[6:0])) else $error("leveling code wrong");
endmodule // odg_top

// ### tb/odg_core_src.sv
// Purpose: Core-side word source feeding the geared output path
// Assumes: Words are queued by the bench between clock edges
// Notes: Holds valid and word until taken; scrambles the word when idle
module odg_core_src
  import odg_pkg::*;
(
  // Clock and reset
  input wire logic clk,
  input wire logic sys_rst,
  // Word stream towards the block
  output logic core_valid,
  input wire logic core_ready,
  output odg_pkg::odg_word_t core_word
);
  timeunit 1ns;
  timeprecision 1ps;
  // Words waiting to be offered
  odg_word_t q[$];

  // Append one word to the outgoing stream
  task automatic push(input odg_word_t w);
    q.push_back(w);
  endtask

  // Offer the head word; drop it once valid and ready meet at an edge
  always @(posedge clk or posedge sys_rst)
  begin
    if (sys_rst)
    begin
      core_valid <= 1'b0;
      core_word <= '0;
    end
    else
    begin
      if (core_valid && core_ready)
        void'(q.pop_front());
      core_valid <= (q.size() > 0);
      // Idle word is inverted so a stale value is never mistaken for data
      core_word <= (q.size() > 0) ? q[0] : ~core_word;
    end
  end
endmodule // odg_core_src

// ### tb/tb.sv
// Purpose: Self-checking bench for the geared output and tristate path
// Assumes: Avalon-MM master with one outstanding request
// Notes: A top-edge twin shares all inputs to show the gearing fallback
module tb;
  timeunit 1ns;
  timeprecision 1ps;
  import odg_pkg::*;
  // Clock, reset and bus
  logic clk = 1'b0;
  logic sys_rst = 1'b1;
  logic [3:0] adr = 4'h0;
  logic rd = 1'b0;
  logic wr = 1'b0;
  logic [31:0] wdat = 32'h0;
  logic [3:0] be = 4'hF;
  logic [31:0] rdat;
  logic [31:0] rdat_top;
  logic [31:0] top_q;
  logic [31:0] q;
  logic wait_req;
  // Stream and pad side
  logic core_valid;
  logic core_ready;
  odg_word_t core_word;
  odg_pad_t pad;
  logic g0;
  logic g1;
  logic refused = 1'b0;
  int fail_count = 0;
  int total_checks = 0;
  // Mode table: control value and steady word; the last two hold a lone one and a lone zero
  logic [3:0] ctl [9] = '{4'h0, 4'h4, 4'h9, 4'hA, 4'hA, 4'h2, 4'h3, 4'hA, 4'hA};
  logic [4:0] wd [9] = '{5'h01, 5'h00, 5'h01, 5'h05, 5'h13, 5'h05, 5'h0E, 5'h01, 5'h0E};
  // Sampled phases, pad bits and stretch, with the bits the rules predict
  logic [1:0] ph [12];
  logic dh [12];
  logic [2:0] sm [12];
  logic eb [12];
  logic [1:0] lp;
  logic iso;
  logic [7:0] lvl [2] = '{8'h85, 8'h7F};

  always #2.5 clk = ~clk;

  // Left-edge unit under test
  odg_top #(.EDGE(EDGE_LEFT), .FIFO_DEPTH(8)) u_dut (.clk(clk), .sys_rst(sys_rst), .avs_address(adr),
    .avs_read(rd), .avs_write(wr), .avs_writedata(wdat), .avs_byteenable(be), .avs_readdata(rdat),
    .avs_waitrequest(wait_req), .core_valid(core_valid), .core_ready(core_ready), .core_word(core_word),
    .pad(pad), .gear_clock_zero(g0), .gear_clock_one(g1));
  // Top-edge twin, only its read data is watched
  odg_top #(.EDGE(EDGE_TOP), .FIFO_DEPTH(8)) u_dut_top (.clk(clk), .sys_rst(sys_rst), .avs_address(adr),
    .avs_read(rd), .avs_write(wr), .avs_writedata(wdat), .avs_byteenable(be), .avs_readdata(rdat_top),
    .avs_waitrequest(), .core_valid(core_valid), .core_ready(), .core_word(core_word),
    .pad(), .gear_clock_zero(), .gear_clock_one());
  // Core-side partner
  odg_core_src u_src (.clk(clk), .sys_rst(sys_rst), .core_valid(core_valid), .core_ready(core_ready),
    .core_word(core_word));

  // Remember that the block pushed back on the stream
  always @(posedge clk)
    if (core_valid && core_ready === 1'b0)
      refused <= 1'b1;

  // Compare one value and count it
  task automatic check(input string name, input logic [31:0] seen, input logic [31:0] exp);
    total_checks++;
    if (seen !== exp)
    begin
      fail_count++;
      $display("CHECK FAILED %s expected %h seen %h", name, exp, seen);
    end
  endtask

  // One bus access; held until waitrequest is sampled low
  task automatic bus(input logic is_wr, input logic [3:0] a, input logic [31:0] d, input logic [3:0] b);
    rd <= !is_wr;
    wr <= is_wr;
    adr <= a;
    wdat <= d;
    be <= b;
    @(posedge clk);
    // Only the watchdog ends a wait that never finishes
    while (wait_req !== 1'b0)
      @(posedge clk);
    q = rdat;
    top_q = rdat_top;
    rd <= 1'b0;
    wr <= 1'b0;
    @(posedge clk);
  endtask

  // Read a register and compare
  task automatic rd_chk(input string name, input logic [3:0] a, input logic [31:0] exp);
    bus(1'b0, a, 32'h0, 4'hF);
    check(name, q, exp);
  endtask

  // Print counts and the verdict, then stop
  task automatic give_verdict();
    $display("checks %0d mismatches %0d", total_checks, fail_count);
    if (fail_count == 0 && total_checks > 0)
      $display("RESULT: PASS");
    else
      $display("RESULT: FAIL");
    $finish;
  endtask

  // Watchdog against a hung handshake
  initial
  begin
    repeat (20000) @(posedge clk);
    fail_count++;
    give_verdict();
  end

  // Main sequence
  initial
  begin
    repeat (12) @(posedge clk);
    sys_rst <= 1'b0;
    @(posedge clk);
    rd_chk("ctrl reset", OFS_CTRL, 32'h0);
    bus(1'b1, OFS_SMEAR, 32'h5, 4'hF);
    rd_chk("smear amount", OFS_SMEAR, 32'h5);
    // Each mode with a steady word; pad bits follow the phase counter
    for (int k = 0; k < 9; k++)
    begin
      bus(1'b1, OFS_CTRL, {28'h0, ctl[k]}, 4'hF);
      rd_chk("ctrl", OFS_CTRL, {28'h0, ctl[k]});
      @(negedge clk);
      u_src.push(wd[k]);
      repeat (20) @(posedge clk);
      for (int i = 0; i < 12; i++)
      begin
        @(posedge clk);
        ph[i] = {g1, g0};
        dh[i] = pad.data;
        sm[i] = pad.smear_delay;
      end
      // Last phase of a word from the requested mode; this instance sits on the left edge
      lp = ctl[k][1] ? LAST_PH_GEAR : (ctl[k][0] ? LAST_PH_DDR : LAST_PH_SDR);
      for (int i = 2; i < 12; i++)
      begin
        eb[i] = wd[k][ph[i-2]];
        check("pad data", {31'h0, dh[i]}, {31'h0, eb[i]});
        check("gear phase", {30'h0, ph[i]}, {30'h0, ((ph[i-1] == lp) ? 2'h0 : ph[i-1] + 2'h1)});
      end
      check("pad oe", {31'h0, pad.oe}, {31'h0, ~wd[k][4]});
      // A bit that differs from both neighbours is stretched, only when geared and enabled
      for (int i = 3; i < 11; i++)
      begin
        iso = ctl[k][3] && ctl[k][1] && (eb[i] != eb[i-1]) && (eb[i] != eb[i+1]);
        check("stretch", {29'h0, sm[i]}, {29'h0, (iso ? 3'h5 : 3'h0)});
      end
    end
    // Gearing request on both edges
    bus(1'b1, OFS_CTRL, 32'h2, 4'hF);
    bus(1'b0, OFS_STATUS, 32'h0, 4'hF);
    check("left mode", q[1:0], 32'h2);
    check("top mode", top_q[1:0], 32'h1);
    // Leveling code split into steps and inversion
    for (int k = 0; k < 2; k++)
    begin
      bus(1'b1, OFS_LEVEL, {24'h0, lvl[k]}, 4'hF);
      rd_chk("level", OFS_LEVEL, {24'h0, lvl[k]});
      check("level steps", {25'h0, pad.level_steps}, {25'h0, lvl[k][6:0]});
      check("level invert", {31'h0, pad.level_invert}, {31'h0, lvl[k][7]});
    end
    // Disabled lanes and holes in the map leave state alone
    bus(1'b1, OFS_SMEAR, 32'h7, 4'h0);
    rd_chk("smear kept", OFS_SMEAR, 32'h5);
    bus(1'b1, 4'h1, 32'hFF, 4'hF);
    rd_chk("unmapped", 4'h1, 32'h0);
    // Burst beyond the buffer depth, then let it drain
    @(negedge clk);
    repeat (12) u_src.push(5'h05);
    repeat (80) @(posedge clk);
    check("refused", {31'h0, refused}, 32'h1);
    bus(1'b0, OFS_STATUS, 32'h0, 4'hF);
    check("fifo empty", {28'h0, q[7:4]}, 32'h0);
    give_verdict();
  end
endmodule // tb
